//--- logic/axis_pkg.sv
// Constants, register map and carrier types for the axis position monitor
package axis_pkg;
    localparam int          CLK_HZ          = 125000000;
    localparam int          ZM_MIN_US_X100  = 833;
    localparam int          ZM_MIN_CYC      = (ZM_MIN_US_X100 * (CLK_HZ / 1000000) + 99) / 100;

    localparam logic [31:0] TRAVEL_MAX      = 32'sd500000000;
    localparam logic [31:0] TRAVEL_MIN      = -32'sd500000000;
    localparam logic [31:0] ROT_END_MAX     = 32'd1000000000;
    localparam logic [31:0] PPR_MAX         = 32'h0080_0000;
    localparam logic [31:0] PULSES_PER_INC  = 32'd4;
    localparam logic [31:0] ZM_DIV_TEN      = 32'd10;
    localparam logic [31:0] ZM_DIV_SIXTEEN  = 32'd16;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_ROT_END     = 8'h04;
    localparam logic [7:0]  OFS_LIM_LOW     = 8'h08;
    localparam logic [7:0]  OFS_LIM_HIGH    = 8'h0c;
    localparam logic [7:0]  OFS_REF_COORD   = 8'h10;
    localparam logic [7:0]  OFS_INC_REV     = 8'h14;
    localparam logic [7:0]  OFS_CMD         = 8'h18;
    localparam logic [7:0]  OFS_STATUS      = 8'h1c;
    localparam logic [7:0]  OFS_POSITION    = 8'h20;
    localparam logic [7:0]  OFS_REF_POS     = 8'h24;
    localparam logic [7:0]  OFS_MEAS_LEN    = 8'h28;

    // Control field positions
    localparam int          B_ROTARY        = 0;
    localparam int          B_REF_MINUS     = 1;
    localparam int          B_INVERT        = 2;
    localparam int          B_WR_MON        = 3;
    localparam int          B_ZM_MON        = 4;
    localparam int          B_DIAG_EN       = 5;
    localparam int          B_DI_TRAV       = 6;
    localparam int          B_DI_WORK       = 7;
    localparam int          B_DI_ZM         = 8;
    localparam int          B_LM_LO         = 9;
    localparam int          B_LM_HI         = 11;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0008;

    // Command bits (write one)
    localparam int          C_RUN           = 0;
    localparam int          C_STOP          = 1;
    localparam int          C_REF_DONE      = 2;

    localparam logic [31:0] ROT_END_RESET   = 32'd100000;
    localparam logic [31:0] LIM_LOW_RESET   = -32'sd100000000;
    localparam logic [31:0] LIM_HIGH_RESET  = 32'sd100000000;
    localparam logic [31:0] REF_RESET       = 32'h0000_0000;
    localparam logic [31:0] INC_REV_RESET   = 32'd1000;

    typedef enum logic [2:0] {
        LM_OFF, LM_RISE_RISE, LM_FALL_FALL, LM_RISE_FALL, LM_FALL_RISE
    } meas_mode_t;

    typedef struct packed {
        logic a;
        logic b;
        logic n;
    } enc_t;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;
endpackage : axis_pkg

//--- logic/axis_position_monitor.sv
// Axis position tracking, limit and zero-mark monitors with a Wishbone slave
// Notes on behaviour
// - Axis type linear or rotary, linear default
// - Rotary position wraps between zero and end-1
// - Rotary end 1..1e9, default 100000, non-negative
// - Soft limits bound linear working range inclusively
// - Limits checked only synchronized with monitoring on
// - Run start: unsynchronized, position gets reference coordinate
// - Reference approach done assigns reference coordinate
// - Reference point on plus or minus side
// - Five length measurement edge modes, off default
// - Traversing range exceed cancels sync, aborts run
// - Working range exceed cancels run, linear only
// - Increments per revolution 1..2^23, fourfold evaluation
// - Count direction normal or inverted
// - Zero mark pulse spacing checked when enabled
// - Zero mark check off unless ppr divisible 10/16
// - Zero mark failure cancels sync, aborts run
// - Responding monitors may raise diagnostic interrupt
// - Diagnostic needs global and per-monitor enable
`timescale 1ns/1ps
module axis_position_monitor
(
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST_B,
    // Wishbone slave
    input  wire axis_pkg::wb_req_t     WB_REQ,
    output logic                       WB_ACK,
    output logic [31:0]                WB_DAT_O,
    // Encoder and switch pins
    input  wire axis_pkg::enc_t        ENC,
    input  wire logic                  REF_SWITCH,
    input  wire logic                  LENGTH_MEASURE_INPUT,
    // Status
    output logic                       RUNNING,
    output logic                       SYNCED,
    output logic                       RUN_ABORT,
    output logic                       DIAG_IRQ
);
    import axis_pkg::*;

    function automatic logic signed [31:0] wrap(input logic signed [31:0] p,
                                               input logic [31:0] e);
        logic signed [31:0] r;
        r = p;
        if (p < 0)
            r = p + $signed(e);
        else if (p >= $signed(e))
            r = p - $signed(e);
        return r;
    endfunction : wrap

    // Synchronisers; first stage read only by second
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
        end
        else
        begin
            s1 <= {ENC.a, ENC.b, ENC.n, REF_SWITCH, LENGTH_MEASURE_INPUT};
            s2 <= s1;
            s3 <= s2;
        end
    end
    logic a, b, a_q, b_q, n, n_q, rs, rs_q, di, di_q;
    assign {a, b, n, rs, di} = s2;
    assign {a_q, b_q, n_q, rs_q, di_q} = s3;

    // Quadrature decode: an edge of A or of B alone is one pulse; edges of both in one cycle give none
    logic step, up;
    always_comb
    begin
        step = (a ^ a_q) ^ (b ^ b_q);
        up   = (a ^ b_q);
    end

    // Configuration registers
    logic [31:0]        ctrl, rot_end, inc_rev;
    logic signed [31:0] lim_low, lim_high, ref_coord;
    logic [31:0]        next_ctrl, next_rot_end, next_inc_rev;
    logic signed [31:0] next_lim_low, next_lim_high, next_ref_coord;
    logic               wr, cmd_run, cmd_stop, cmd_ref;
    logic               next_ack;
    logic [31:0]        next_rd;

    // Axis state
    logic signed [31:0] pos, ref_pos, meas_start, meas_len;
    logic signed [31:0] next_pos, next_ref_pos, next_meas_start, next_meas_len;
    logic               running, synced, abort, diag, meas_act, zm_seen;
    logic               next_running, next_synced, next_abort, next_diag;
    logic               next_meas_act, next_zm_seen;
    logic [31:0]        zm_cnt, next_zm_cnt;
    logic [2:0]         status;
    logic [2:0]         next_status;
    logic [31:0]        rev_pulses;

    logic               rotary, zm_ok, trav_err, work_err, zm_err;
    meas_mode_t         lm;
    logic               di_rise, di_fall, lm_start, lm_end;

    always_comb
    begin
        rotary  = ctrl[B_ROTARY];
        lm      = meas_mode_t'(ctrl[B_LM_HI:B_LM_LO]);
        // Modulo on a 26-bit value; checked once per config, not per pulse
        rev_pulses = inc_rev * PULSES_PER_INC;
        zm_ok   = ctrl[B_ZM_MON] &&
                  (rev_pulses % ZM_DIV_TEN == 32'd0 ||
                   rev_pulses % ZM_DIV_SIXTEEN == 32'd0);
        di_rise = di & ~di_q;
        di_fall = ~di & di_q;
        unique case (lm)
            LM_RISE_RISE: begin lm_start = di_rise; lm_end = di_rise; end
            LM_FALL_FALL: begin lm_start = di_fall; lm_end = di_fall; end
            LM_RISE_FALL: begin lm_start = di_rise; lm_end = di_fall; end
            LM_FALL_RISE: begin lm_start = di_fall; lm_end = di_rise; end
            default:      begin lm_start = 1'b0;    lm_end = 1'b0;    end
        endcase
    end

    // Bus decode
    always_comb
    begin
        wr       = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && !WB_ACK;
        next_ack = WB_REQ.cyc && WB_REQ.stb && !WB_ACK;
        next_ctrl      = ctrl;
        next_rot_end   = rot_end;
        next_lim_low   = lim_low;
        next_lim_high  = lim_high;
        next_ref_coord = ref_coord;
        next_inc_rev   = inc_rev;
        cmd_run  = 1'b0;
        cmd_stop = 1'b0;
        cmd_ref  = 1'b0;
        if (wr && WB_REQ.sel == 4'hf)
        begin
            unique case (WB_REQ.adr)
                OFS_CTRL:      next_ctrl      = WB_REQ.dat;
                OFS_ROT_END:   if (WB_REQ.dat != 32'h0 && WB_REQ.dat <= ROT_END_MAX)
                                   next_rot_end = WB_REQ.dat;
                OFS_LIM_LOW:   next_lim_low   = WB_REQ.dat;
                OFS_LIM_HIGH:  next_lim_high  = WB_REQ.dat;
                OFS_REF_COORD: next_ref_coord = WB_REQ.dat;
                OFS_INC_REV:   if (WB_REQ.dat != 32'h0 && WB_REQ.dat <= PPR_MAX)
                                   next_inc_rev = WB_REQ.dat;
                OFS_CMD:
                begin
                    cmd_run  = WB_REQ.dat[C_RUN];
                    cmd_stop = WB_REQ.dat[C_STOP];
                    cmd_ref  = WB_REQ.dat[C_REF_DONE];
                end
                default: ;
            endcase
        end
        unique case (WB_REQ.adr)
            OFS_CTRL:      next_rd = ctrl;
            OFS_ROT_END:   next_rd = rot_end;
            OFS_LIM_LOW:   next_rd = lim_low;
            OFS_LIM_HIGH:  next_rd = lim_high;
            OFS_REF_COORD: next_rd = ref_coord;
            OFS_INC_REV:   next_rd = inc_rev;
            OFS_STATUS:    next_rd = {26'h0, status, diag, synced, running};
            OFS_POSITION:  next_rd = pos;
            OFS_REF_POS:   next_rd = ref_pos;
            OFS_MEAS_LEN:  next_rd = meas_len;
            default:       next_rd = 32'h0;
        endcase
    end

    // Axis behaviour
    always_comb
    begin
        logic signed [31:0] p;
        logic               dir_up;
        p = pos;
        dir_up = up ^ ctrl[B_INVERT];
        next_running = running;
        next_synced  = synced;
        next_abort   = 1'b0;
        next_diag    = diag;
        next_status  = status;
        next_ref_pos = ref_pos;
        next_meas_start = meas_start;
        next_meas_len   = meas_len;
        next_meas_act   = meas_act;
        next_zm_cnt     = zm_cnt;
        next_zm_seen    = zm_seen;
        trav_err = 1'b0;
        work_err = 1'b0;
        zm_err   = 1'b0;
        if (step)
        begin
            p = dir_up ? pos + 32'sd1 : pos - 32'sd1;
            if (rotary)
                p = wrap(p, rot_end);
            next_zm_cnt = zm_cnt + 32'd1;
        end
        // Zero mark spacing must be one revolution of pulses
        if (n & ~n_q & zm_ok)
        begin
            if (zm_seen && next_zm_cnt != rev_pulses)
                zm_err = 1'b1;
            next_zm_seen = 1'b1;
            next_zm_cnt  = 32'h0;
        end
        if (rs & ~rs_q && (dir_up ^ ctrl[B_REF_MINUS]))
            next_zm_cnt = 32'h0;
        trav_err = (p > $signed(TRAVEL_MAX)) || (p < $signed(TRAVEL_MIN));
        work_err = !rotary && synced && ctrl[B_WR_MON] &&
                   ((p < lim_low) || (p > lim_high));
        if (lm_start && !meas_act)
        begin
            next_meas_start = p;
            next_meas_act   = 1'b1;
        end
        else if (lm_end && meas_act)
        begin
            next_meas_len = p - meas_start;
            next_meas_act = 1'b0;
        end
        if (cmd_ref)
        begin
            p           = ref_coord;
            next_ref_pos = ref_coord;
            next_synced = 1'b1;
        end
        if (trav_err || zm_err)
            next_synced = 1'b0;
        if (running && (trav_err || zm_err || work_err))
        begin
            next_running = 1'b0;
            next_abort   = 1'b1;
        end
        if (trav_err || zm_err || work_err)
            next_status = status | {zm_err, work_err, trav_err};
        // Both global and per-monitor enable needed
        if (ctrl[B_DIAG_EN] && ((trav_err && ctrl[B_DI_TRAV]) ||
            (work_err && ctrl[B_DI_WORK]) || (zm_err && ctrl[B_DI_ZM])))
            next_diag = 1'b1;
        else if (wr && WB_REQ.adr == OFS_STATUS)
            next_diag = 1'b0;
        if (wr && WB_REQ.adr == OFS_STATUS)
            next_status = {zm_err, work_err, trav_err};
        if (cmd_stop)
            next_running = 1'b0;
        if (cmd_run && !running)
        begin
            next_running = 1'b1;
            next_synced  = 1'b0;
            p            = ref_coord;
            next_zm_seen = 1'b0;
        end
        next_pos = p;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl <= CTRL_RESET;
            rot_end <= ROT_END_RESET;
            lim_low <= LIM_LOW_RESET;
            lim_high <= LIM_HIGH_RESET;
            ref_coord <= REF_RESET;
            inc_rev <= INC_REV_RESET;
            WB_ACK <= 1'b0;
            WB_DAT_O <= 32'h0;
            pos <= REF_RESET;
            ref_pos <= REF_RESET;
            meas_start <= 32'h0;
            meas_len <= 32'h0;
            meas_act <= 1'b0;
            running <= 1'b0;
            synced <= 1'b0;
            abort <= 1'b0;
            diag <= 1'b0;
            status <= 3'h0;
            zm_cnt <= 32'h0;
            zm_seen <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            rot_end <= next_rot_end;
            lim_low <= next_lim_low;
            lim_high <= next_lim_high;
            ref_coord <= next_ref_coord;
            inc_rev <= next_inc_rev;
            WB_ACK <= next_ack;
            WB_DAT_O <= next_rd;
            pos <= next_pos;
            ref_pos <= next_ref_pos;
            meas_start <= next_meas_start;
            meas_len <= next_meas_len;
            meas_act <= next_meas_act;
            running <= next_running;
            synced <= next_synced;
            abort <= next_abort;
            diag <= next_diag;
            status <= next_status;
            zm_cnt <= next_zm_cnt;
            zm_seen <= next_zm_seen;
        end
    end

    assign RUNNING   = running;
    assign SYNCED    = synced;
    assign RUN_ABORT = abort;
    assign DIAG_IRQ  = diag;

    a_rotary_range: assert property (@(posedge CLK) disable iff (!RST_B)
        rotary && !$past(cmd_run) |-> pos >= 0)
        else $error("rotary position negative");
    a_trav_abort: assert property (@(posedge CLK) disable iff (!RST_B)
        running && trav_err |=> !synced && !running && abort)
        else $error("travel exceed not handled");
    a_work_abort: assert property (@(posedge CLK) disable iff (!RST_B)
        running && work_err |=> !running ##0 abort)
        else $error("working range exceed not handled");
    a_work_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        (!synced || rotary || !ctrl[B_WR_MON]) && !trav_err && !zm_err |=> !abort)
        else $error("limit check while not allowed");
    a_run_start: assert property (@(posedge CLK) disable iff (!RST_B)
        cmd_run && !running |=> running && !synced && pos == $past(ref_coord))
        else $error("run start wrong");
    a_ref_assign: assert property (@(posedge CLK) disable iff (!RST_B)
        cmd_ref && !cmd_run && !trav_err && !zm_err |=> synced && ref_pos == $past(ref_coord))
        else $error("reference not assigned");
    a_zm_forced_off: assert property (@(posedge CLK) disable iff (!RST_B)
        zm_err |-> ctrl[B_ZM_MON] && (inc_rev % 32'd5 == 32'd0 || inc_rev % 32'd4 == 32'd0))
        else $error("zero mark check while off");
    a_zm_abort: assert property (@(posedge CLK) disable iff (!RST_B)
        zm_err |=> !synced)
        else $error("zero mark error kept sync");
    a_diag_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(diag) |-> $past(ctrl[B_DIAG_EN]))
        else $error("diag without global enable");
    a_step_one: assert property (@(posedge CLK) disable iff (!RST_B)
        step && !rotary && !cmd_run && !cmd_ref |=> (pos - $past(pos) == 1) ||
        ($past(pos) - pos == 1))
        else $error("step not one pulse");
    c_rot_wrap: cover property (@(posedge CLK) rotary && step && pos == 0);
    c_abort: cover property (@(posedge CLK) abort);
    c_meas: cover property (@(posedge CLK) lm_end && meas_act);
    c_diag: cover property (@(posedge CLK) $rose(diag));
endmodule : axis_position_monitor

//--- testbench/quad_encoder_model.sv
// Behavioural incremental encoder with tracks a, b and zero mark n
`timescale 1ns/1ps
module quad_encoder_model
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    // Motion requests, one cycle each
    input  wire logic      step_fwd,
    input  wire logic      step_bwd,
    input  wire logic      zm_req,
    // Encoder tracks
    output axis_pkg::enc_t enc
);
    import axis_pkg::*;

    logic [1:0] phase;
    logic [1:0] next_phase;
    int         zm_cnt;
    int         next_zm_cnt;

    always_comb
    begin
        next_phase  = phase + {1'b0, step_fwd} - {1'b0, step_bwd};
        // Zero mark held for the minimum width, never shorter
        next_zm_cnt = zm_req ? ZM_MIN_CYC : ((zm_cnt > 0) ? zm_cnt - 1 : 0);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase  <= 2'h0;
            zm_cnt <= 0;
        end
        else
        begin
            phase  <= next_phase;
            zm_cnt <= next_zm_cnt;
        end
    end

    // Gray sequence 00,10,11,01: track a leads b by a quarter period going forward
    assign enc.a = (phase == 2'h1) || (phase == 2'h2);
    assign enc.b = (phase == 2'h2) || (phase == 2'h3);
    assign enc.n = (zm_cnt != 0);
endmodule : quad_encoder_model

//--- testbench/axis_position_monitor_test.sv
// Self-checking bench for the axis position monitor
`timescale 1ns/1ps
module axis_position_monitor_test;
    import axis_pkg::*;

    logic              CLK;
    logic              RST_B;
    wb_req_t           req;
    logic              WB_ACK;
    logic [31:0]       WB_DAT_O;
    enc_t              enc;
    logic              ref_sw;
    logic              meas_in;
    logic              RUNNING;
    logic              SYNCED;
    logic              RUN_ABORT;
    logic              DIAG_IRQ;
    logic              sf;
    logic              sb;
    logic              zq;
    int                n_errors;
    int                n_compared;
    int                n_abort;
    int                cycles;
    int                mpos;
    int                rot_end;
    int                rref;
    int                nlen;
    bit                inv;
    bit                rot;

    axis_position_monitor dut (.CLK(CLK), .RST_B(RST_B), .WB_REQ(req), .WB_ACK(WB_ACK),
        .WB_DAT_O(WB_DAT_O), .ENC(enc), .REF_SWITCH(ref_sw), .LENGTH_MEASURE_INPUT(meas_in),
        .RUNNING(RUNNING), .SYNCED(SYNCED), .RUN_ABORT(RUN_ABORT), .DIAG_IRQ(DIAG_IRQ));

    quad_encoder_model encoder (.clk(CLK), .rst_b(RST_B), .step_fwd(sf), .step_bwd(sb),
        .zm_req(zq), .enc(enc));

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // Hang guard well above the expected run length
    always @(posedge CLK)
    begin
        cycles++;
        if (RUN_ABORT === 1'b1)
            n_abort++;
        if (cycles == 60000)
        begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp32

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp1

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge CLK);
        req <= '{1'b1, 1'b1, we, sel, adr, dat};
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (WB_ACK !== 1'b1 && n < 50);
        rd = WB_DAT_O;
        if (n >= 50)
            n_errors++;
        req <= '0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb(1'b1, adr, dat, 4'hf, rd);
    endtask : wr

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 32'h0, 4'hf, rd);
        cmp32(rd, exp);
    endtask : rdc

    task automatic flags(input logic run, input logic syn);
        @(negedge CLK);
        cmp1(RUNNING, run);
        cmp1(SYNCED, syn);
    endtask : flags

    // Moves the encoder and the reference model together
    task automatic step(input int n, input bit fwd);
        repeat (n)
        begin
            @(posedge CLK);
            sf <= fwd;
            sb <= !fwd;
            @(posedge CLK);
            sf <= 1'b0;
            sb <= 1'b0;
            repeat (5) @(posedge CLK);
            mpos += (fwd ^ inv) ? 1 : -1;
            if (rot)
                mpos = (mpos + rot_end) % rot_end;
        end
    endtask : step

    task automatic zmark();
        @(posedge CLK);
        zq <= 1'b1;
        @(posedge CLK);
        zq <= 1'b0;
        repeat (ZM_MIN_CYC + 8) @(posedge CLK);
    endtask : zmark

    // Leaves time for the pin to pass the synchroniser
    task automatic meas_edge(input logic lvl);
        @(posedge CLK);
        meas_in <= lvl;
        repeat (4) @(posedge CLK);
    endtask : meas_edge

    task automatic start_sync(input int r);
        wr(OFS_REF_COORD, r);
        wr(OFS_CMD, 32'h1);
        wr(OFS_CMD, 32'h4);
        mpos = r;
    endtask : start_sync

    initial
    begin
        logic [31:0] rd;
        req = '0;
        sf = 1'b0;
        sb = 1'b0;
        zq = 1'b0;
        ref_sw = 1'b0;
        meas_in = 1'b0;
        RST_B = 1'b0;
        inv = 0;
        rot = 0;
        rot_end = 1000;
        void'($urandom(32'h1993));
        repeat (4) @(posedge CLK);
        RST_B <= 1'b1;
        rdc(OFS_CTRL, CTRL_RESET);
        rdc(OFS_ROT_END, ROT_END_RESET);
        rdc(OFS_LIM_LOW, LIM_LOW_RESET);
        rdc(OFS_LIM_HIGH, LIM_HIGH_RESET);
        rdc(OFS_REF_COORD, REF_RESET);
        rdc(OFS_INC_REV, INC_REV_RESET);
        rdc(8'h2c, 32'h0);
        for (int m = 0; m < 5; m++)
        begin
            wr(OFS_CTRL, CTRL_RESET | (m << B_LM_LO));
            rdc(OFS_CTRL, CTRL_RESET | (m << B_LM_LO));
        end
        $display("test registers done");
        // Run start leaves the axis unsynchronised; limits then do not apply
        rref = $urandom_range(1000) - 500;
        wr(OFS_CTRL, CTRL_RESET);
        wr(OFS_REF_COORD, rref);
        wb(1'b1, OFS_REF_COORD, 32'h5, 4'h3, rd);
        rdc(OFS_REF_COORD, rref);
        wr(OFS_LIM_HIGH, rref + 2);
        wr(OFS_CMD, 32'h1);
        mpos = rref;
        flags(1'b1, 1'b0);
        rdc(OFS_POSITION, mpos);
        step($urandom_range(4) + 3, 1);
        rdc(OFS_POSITION, mpos);
        flags(1'b1, 1'b0);
        inv = 1;
        wr(OFS_CTRL, CTRL_RESET | 32'h4);
        step($urandom_range(5) + 8, 1);
        rdc(OFS_POSITION, mpos);
        $display("test count done");
        // Length measurement in both edge orders
        inv = 0;
        wr(OFS_CTRL, CTRL_RESET | (32'h3 << B_LM_LO));
        nlen = $urandom_range(5) + 2;
        meas_edge(1'b1);
        step(nlen, 1);
        meas_edge(1'b0);
        rdc(OFS_MEAS_LEN, nlen);
        wr(OFS_CTRL, CTRL_RESET | (32'h4 << B_LM_LO));
        meas_edge(1'b1);
        meas_edge(1'b0);
        step(nlen, 0);
        meas_edge(1'b1);
        rdc(OFS_MEAS_LEN, -nlen);
        $display("test measure done");
        // Working range: limit itself is inside, one beyond aborts
        inv = 0;
        wr(OFS_CTRL, 32'ha8);
        start_sync(rref);
        flags(1'b1, 1'b1);
        rdc(OFS_REF_POS, rref);
        n_abort = 0;
        step(2, 1);
        flags(1'b1, 1'b1);
        step(1, 1);
        cmp32(n_abort, 1);
        flags(1'b0, 1'b1);
        cmp1(DIAG_IRQ, 1'b1);
        rdc(OFS_STATUS, 32'h16);
        // Back inside the range, or the monitor keeps responding
        step(1, 0);
        wr(OFS_STATUS, 32'h0);
        cmp1(DIAG_IRQ, 1'b0);
        $display("test working range done");
        // Rotary wrap at both ends
        // Synchronise inside both ranges before the axis turns rotary
        wr(OFS_LIM_HIGH, TRAVEL_MAX);
        start_sync(rot_end - 1);
        rot = 1;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_ROT_END, rot_end);
        wr(OFS_ROT_END, 32'h0);
        rdc(OFS_ROT_END, rot_end);
        step(1, 1);
        rdc(OFS_POSITION, 32'h0);
        step(3, 0);
        rdc(OFS_POSITION, mpos);
        $display("test rotary done");
        // Traversing range: fixed check, diagnostic enabled for it
        rot = 0;
        wr(OFS_CTRL, 32'h60);
        n_abort = 0;
        start_sync(TRAVEL_MAX);
        step(1, 1);
        cmp32(n_abort, 1);
        flags(1'b0, 1'b0);
        cmp1(DIAG_IRQ, 1'b1);
        wr(OFS_STATUS, 32'h0);
        $display("test traversing done");
        // Zero mark: one good revolution, then a short one
        wr(OFS_CTRL, 32'h10);
        wr(OFS_INC_REV, 32'h4);
        n_abort = 0;
        start_sync(0);
        zmark();
        step(16, 1);
        zmark();
        flags(1'b1, 1'b1);
        step(15, 1);
        zmark();
        cmp32(n_abort, 1);
        flags(1'b0, 1'b0);
        wr(OFS_INC_REV, 32'h3);
        start_sync(0);
        zmark();
        step(5, 1);
        zmark();
        flags(1'b1, 1'b1);
        $display("test zero mark done");
        final_report();
    end
endmodule : axis_position_monitor_test
